// >>> core/brs_cfg_if.sv
// Purpose: carrier between sequencer and configuration store
// Assumes: one clock
// Notes:   the store answers reads one cycle later
`timescale 1ns/100ps
interface brs_cfg_if;
    logic        writeEn;
    logic        writeSel;
    logic [15:0] writeData;
    logic        readEn;
    logic        readSel;
    logic [15:0] readData;
    logic [15:0] cfg0;
    logic [15:0] cfg1;

    modport store (
        input  writeEn, writeSel, writeData, readEn, readSel,
        output readData, cfg0, cfg1
    );
    modport user (
        output writeEn, writeSel, writeData, readEn, readSel,
        input  readData, cfg0, cfg1
    );
endinterface : brs_cfg_if

// >>> core/brs_cfg_regs.sv
// Purpose: the two configuration words with registered read-back
// Assumes: writes come from the decoded set-configuration command
// Notes:   reset restores the defaults
`timescale 1ns/100ps
`include "brs_regs.svh"
module brs_cfg_regs
    import brs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // configuration access
    brs_cfg_if.store cfg
);
    brs_cfg_type s;
    brs_cfg_type next_s;

    always_comb begin
        next_s = s;
        if (cfg.writeEn && cfg.writeSel == `BRS_SEL_CFG0) begin
            next_s.cfg0 = cfg.writeData;
        end
        if (cfg.writeEn && cfg.writeSel == `BRS_SEL_CFG1) begin
            next_s.cfg1 = cfg.writeData;
        end
        if (cfg.readEn) begin
            next_s.readData = (cfg.readSel == `BRS_SEL_CFG1) ? s.cfg1 : s.cfg0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s.cfg0     <= `BRS_CFG0_RESET;
            s.cfg1     <= `BRS_CFG1_RESET;
            s.readData <= 16'h0000;
        end else begin
            s <= next_s;
        end
    end

    assign cfg.cfg0     = s.cfg0;
    assign cfg.cfg1     = s.cfg1;
    assign cfg.readData = s.readData;
endmodule : brs_cfg_regs

// >>> core/brs_pkg.sv
// Purpose: shared types of the burst read address sequencer
// Assumes: nothing beyond the constants header
// Notes:   the wide state record lives in the top module, its width is a parameter
package brs_pkg;

    typedef enum logic [2:0] {
        BRS_IDLE,
        BRS_BURST,
        BRS_STATUS
    } brs_state_type;

    typedef struct packed {
        logic [15:0] cfg0;
        logic [15:0] cfg1;
        logic [15:0] readData;
    } brs_cfg_type;

endpackage : brs_pkg

// >>> core/brs_regs.svh
// Purpose: constants of the burst read address sequencer
// Assumes: word addressing, 16-bit configuration words
// Notes:   field positions index the two configuration words
`ifndef BRS_REGS_SVH
`define BRS_REGS_SVH

// configuration word selectors
`define BRS_SEL_CFG0        1'h0
`define BRS_SEL_CFG1        1'h1

// reset values
`define BRS_CFG0_RESET      16'h2FC8
`define BRS_CFG1_RESET      16'h0001

// field positions in configuration word zero
`define BRS_MODE_LSB        0
`define BRS_WRAP_BIT        3
`define BRS_RDY_WITH_DATA   8
`define BRS_RDY_POL_BIT     10
`define BRS_WAIT_LSB        11
// wait-state code msb sits in word one
`define BRS_WAIT_HI_BIT     0

// burst mode codes
`define BRS_MODE_CONT       3'h0
`define BRS_MODE_LIN8       3'h2
`define BRS_MODE_LIN16      3'h3
`define BRS_MODE_LIN32      3'h4

// line size in words and address bits, then wait-state counts
`define BRS_LINE_WORDS      128
`define BRS_LINE_BITS       7
`define BRS_WAIT_REF        9
`define BRS_WAIT_LOW_MAX    6
`define BRS_WAIT_LOW_ADD    2

`endif

// >>> core/brs_sequencer.sv
// Purpose: burst read address sequencing for a multiplexed-bus flash
// Assumes: host drives clk, chipSelectN, addr_valid_strobe_n and resetPinN synchronous to clk
// Notes:   array data path lives outside; this block emits word addresses and ready
`timescale 1ns/100ps
`include "brs_regs.svh"
module brs_sequencer
    import brs_pkg::*;
#(
    parameter int ADDR_W    = 24,
    parameter int BANK_BITS = 4
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset,
    // host burst pins
    input  wire logic                    chipSelectN,
    input  wire logic                    addr_valid_strobe_n,
    input  wire logic                    resetPinN,
    input  wire logic [ADDR_W-1:0]       startAddr,
    // bank activity from the array controller
    input  wire logic [2**BANK_BITS-1:0] bankBusy,
    // configuration commands
    input  wire logic                    cfgWriteEn,
    input  wire logic                    cfgWriteSel,
    input  wire logic [15:0]             cfgWriteData,
    input  wire logic                    cfgReadEn,
    input  wire logic                    cfgReadSel,
    output logic      [15:0]             cfgReadData,
    // burst outputs
    output logic      [ADDR_W-1:0]       wordAddr,
    output logic                         wordValid,
    output logic                         readyOut,
    output logic                         statusOut
);
    // one record holds every register of the sequencer outside the configuration store
    typedef struct packed {
        brs_state_type     state;
        logic [ADDR_W-1:0] addr;
        logic [2:0]        mode;
        logic              wrap;
        logic [5:0]        wordsLeft;
        logic [3:0]        waitCnt;
        logic [3:0]        extraWs;
        logic [ADDR_W-1:0] wordAddr;
        logic              wordValid;
        logic              readyOut;
        logic              statusOut;
    } brs_seq_type;

    brs_seq_type s;
    brs_seq_type next_s;
    brs_cfg_if   cfg ();

    brs_cfg_regs u_cfg_regs (
        .clk   (clk),
        .reset (reset),
        .cfg   (cfg.store)
    );

    assign cfg.writeEn   = cfgWriteEn;
    assign cfg.writeSel  = cfgWriteSel;
    assign cfg.writeData = cfgWriteData;
    assign cfg.readEn    = cfgReadEn;
    assign cfg.readSel   = cfgReadSel;
    assign cfgReadData   = cfg.readData;

    // cycles from address edge to first word; codes 6 and 7 are reserved
    function automatic logic [3:0] initLatency(input logic [3:0] code);
        if (code < 4'(`BRS_WAIT_LOW_MAX)) begin
            initLatency = 4'(code + 4'(`BRS_WAIT_LOW_ADD));
        end else begin
            initLatency = code;
        end
    endfunction : initLatency

    // 0 means continuous
    function automatic logic [5:0] burstLen(input logic [2:0] mode);
        case (mode)
            `BRS_MODE_LIN8:  burstLen = 6'h08;
            `BRS_MODE_LIN16: burstLen = 6'h10;
            `BRS_MODE_LIN32: burstLen = 6'h20;
            default:         burstLen = 6'h00;
        endcase
    endfunction : burstLen

    function automatic logic [BANK_BITS-1:0] bankOf(input logic [ADDR_W-1:0] a);
        bankOf = a[ADDR_W-1 -: BANK_BITS];
    endfunction : bankOf

    // one wait count per burst, fixed by the start offset at the take
    logic [3:0]        waitCode;
    logic [3:0]        latency;
    logic [4:0]        offsetSum;
    logic [5:0]        groupMask;
    logic [ADDR_W-1:0] nextAddr;
    logic              emit;
    logic              linearWrap;

    // host pins share clk with this block, so nothing synchronises them
    always_comb begin
        waitCode   = {cfg.cfg1[`BRS_WAIT_HI_BIT], cfg.cfg0[`BRS_WAIT_LSB +: 3]};
        latency    = initLatency(waitCode);
        offsetSum  = 5'(startAddr[2:0]) + 5'(latency);
        groupMask  = 6'(burstLen(s.mode) - 6'h01);
        linearWrap = s.wrap && burstLen(s.mode) != 6'h00;
        emit       = s.state == BRS_BURST && s.waitCnt == 4'h0;
        if (linearWrap) begin
            nextAddr = (s.addr & ~ADDR_W'(groupMask)) | (ADDR_W'(s.addr + 1'b1) & ADDR_W'(groupMask));
        end else begin
            nextAddr = ADDR_W'(s.addr + 1'b1);
        end

        next_s           = s;
        next_s.wordValid = 1'b0;

        // ending the burst outranks a strobe in the same cycle
        if (!resetPinN || chipSelectN) begin
            next_s.state     = BRS_IDLE;
            next_s.statusOut = 1'b0;
        end else if (!addr_valid_strobe_n) begin
            next_s.state     = BRS_BURST;
            next_s.addr      = startAddr;
            next_s.mode      = cfg.cfg0[`BRS_MODE_LSB +: 3];
            next_s.wrap      = cfg.cfg0[`BRS_WRAP_BIT];
            next_s.wordsLeft = burstLen(cfg.cfg0[`BRS_MODE_LSB +: 3]);
            next_s.waitCnt   = 4'(latency - 4'h1);
            next_s.statusOut = 1'b0;
            // later offsets in the first octet pay more at the line edge
            if (offsetSum > 5'(`BRS_WAIT_REF)) begin
                next_s.extraWs = 4'(offsetSum - 5'(`BRS_WAIT_REF));
            end else begin
                next_s.extraWs = 4'h0;
            end
        end else begin
            case (s.state)
                BRS_BURST: begin
                    if (!emit) begin
                        next_s.waitCnt = 4'(s.waitCnt - 4'h1);
                    end else begin
                        next_s.wordValid = 1'b1;
                        next_s.wordAddr  = s.addr;
                        next_s.addr      = nextAddr;
                        if (s.wordsLeft != 6'h00) begin
                            next_s.wordsLeft = 6'(s.wordsLeft - 6'h01);
                        end
                        // the last word of the old bank still goes out beside the status flag
                        if (s.wordsLeft == 6'h01) begin
                            next_s.state = BRS_IDLE;
                        end else if (!linearWrap && bankOf(nextAddr) != bankOf(s.addr)
                                     && bankBusy[bankOf(nextAddr)]) begin
                            next_s.state     = BRS_STATUS;
                            next_s.statusOut = 1'b1;
                        end else if (!linearWrap && nextAddr[`BRS_LINE_BITS-1:0] == '0) begin
                            next_s.waitCnt = s.extraWs;
                        end
                    end
                end
                // clocks ignored until the host strobes a new address
                BRS_STATUS: next_s.state = BRS_STATUS;
                BRS_IDLE:   next_s.state = BRS_IDLE;
                default:    next_s.state = BRS_IDLE;
            endcase
        end

        // ready early means one cycle ahead of the word
        if (cfg.cfg0[`BRS_RDY_WITH_DATA]) begin
            next_s.readyOut = next_s.wordValid;
        end else begin
            next_s.readyOut = next_s.state == BRS_BURST && next_s.waitCnt == 4'h0;
        end
        if (!cfg.cfg0[`BRS_RDY_POL_BIT]) begin
            next_s.readyOut = ~next_s.readyOut;
        end
    end

    // the pin reset ends bursts only; configuration keeps its words
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s.state     <= BRS_IDLE;
            s.addr      <= '0;
            s.mode      <= `BRS_MODE_CONT;
            s.wrap      <= 1'b0;
            s.wordsLeft <= 6'h00;
            s.waitCnt   <= 4'h0;
            s.extraWs   <= 4'h0;
            s.wordAddr  <= '0;
            s.wordValid <= 1'b0;
            s.readyOut  <= 1'b0;
            s.statusOut <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // every burst output straight from the record
    assign wordAddr  = s.wordAddr;
    assign wordValid = s.wordValid;
    assign readyOut  = s.readyOut;
    assign statusOut = s.statusOut;
endmodule : brs_sequencer

// >>> tb/brs_host_model.sv
// Purpose: host controller driving burst read pins
// Assumes: pins change at the falling clock edge
// Notes:   address lines toggle when not strobed
`timescale 1ns/100ps
module brs_host_model
    import brs_pkg::*;
#(
    parameter int ADDR_W = 24
) (
    // clock
    input wire logic          clk,
    // host burst pins
    output logic              chipSelectN,
    output logic              addr_valid_strobe_n,
    output logic              resetPinN,
    output logic [ADDR_W-1:0] startAddr
);
    initial begin
        chipSelectN = 1'b1;
        addr_valid_strobe_n = 1'b1;
        resetPinN = 1'b1;
        startAddr = '0;
    end
    task automatic start(input logic [ADDR_W-1:0] a);
        @(negedge clk);
        chipSelectN = 1'b0;
        resetPinN = 1'b1;
        addr_valid_strobe_n = 1'b0;
        startAddr = a;
        @(negedge clk);
        addr_valid_strobe_n = 1'b1;
        startAddr = ~a;
    endtask : start
    task automatic stop(input bit viaPin);
        @(negedge clk);
        if (viaPin) resetPinN = 1'b0;
        else chipSelectN = 1'b1;
    endtask : stop
endmodule : brs_host_model

// >>> tb/brs_seq_checker.sv
// Purpose: port-level properties of the burst sequencer
// Assumes: ready checks wait for a settled word zero
// Notes:   a shadow of both words follows the write pulses
`timescale 1ns/100ps
`include "brs_regs.svh"
module brs_seq_checker
    import brs_pkg::*;
#(
    parameter int ADDR_W    = 24,
    parameter int BANK_BITS = 4
) (
    // clock and reset
    input wire logic              clk,
    input wire logic              reset,
    // host pins
    input wire logic              chipSelectN,
    input wire logic              addr_valid_strobe_n,
    input wire logic              resetPinN,
    // configuration
    input wire logic              cfgWriteEn,
    input wire logic              cfgWriteSel,
    input wire logic [15:0]       cfgWriteData,
    input wire logic              cfgReadEn,
    input wire logic              cfgReadSel,
    input wire logic [15:0]       cfgReadData,
    // burst outputs
    input wire logic [ADDR_W-1:0] wordAddr,
    input wire logic              wordValid,
    input wire logic              readyOut,
    input wire logic              statusOut
);
    logic [15:0] c0;
    logic [15:0] c1;
    logic [15:0] shadowSel;
    assign shadowSel = cfgReadSel ? c1 : c0;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            c0 <= `BRS_CFG0_RESET;
            c1 <= `BRS_CFG1_RESET;
        end else if (cfgWriteEn && cfgWriteSel) begin
            c1 <= cfgWriteData;
        end else if (cfgWriteEn) begin
            c0 <= cfgWriteData;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_take;
        !chipSelectN && resetPinN && !addr_valid_strobe_n;
    endsequence
    sequence s_end;
        chipSelectN || !resetPinN;
    endsequence
    a_low_bits_step: assert property (wordValid && $past(wordValid)
        |-> wordAddr[2:0] == $past(wordAddr[2:0]) + 3'h1) else $error("word address did not step");
    a_end_quiet: assert property (s_end |-> ##2 (!wordValid && !statusOut))
        else $error("burst kept running after end");
    a_take_gap: assert property (s_take |=> !wordValid ##1 !statusOut)
        else $error("output too soon after address take");
    a_first_due: assert property (s_take |-> ##[2:15] (wordValid || chipSelectN
        || !resetPinN || !addr_valid_strobe_n)) else $error("first word late");
    a_status_quiet: assert property (statusOut |=> !wordValid)
        else $error("word during status");
    a_status_stands: assert property (statusOut && !chipSelectN && resetPinN && addr_valid_strobe_n
        |=> statusOut) else $error("status dropped");
    a_readback_value: assert property (cfgReadEn && !cfgWriteEn
        |=> cfgReadData == $past(shadowSel)) else $error("read-back wrong");
    a_ready_data: assert property (c0[10] && c0[8] && $stable(c0) |-> readyOut == wordValid)
        else $error("ready not with data");
    a_ready_early: assert property (!c0[8] && !c0[10] && $stable(c0) && !readyOut && !chipSelectN
        && resetPinN && addr_valid_strobe_n |=> wordValid) else $error("early ready without word");
endmodule : brs_seq_checker
bind brs_sequencer brs_seq_checker #(.ADDR_W(ADDR_W), .BANK_BITS(BANK_BITS)) chk (.clk(clk), .reset(reset),
    .chipSelectN(chipSelectN), .addr_valid_strobe_n(addr_valid_strobe_n), .resetPinN(resetPinN),
    .cfgWriteEn(cfgWriteEn), .cfgWriteSel(cfgWriteSel), .cfgWriteData(cfgWriteData), .cfgReadEn(cfgReadEn),
    .cfgReadSel(cfgReadSel), .cfgReadData(cfgReadData), .wordAddr(wordAddr), .wordValid(wordValid),
    .readyOut(readyOut), .statusOut(statusOut));

// >>> tb/burst_read_address_sequencer_bench.sv
// Purpose: self-checking bench of the burst sequencer
// Assumes: latency is 8 plus the code until word one is cleared
// Notes:   words are logged one cycle late at each rising edge
`timescale 1ns/100ps
`include "brs_regs.svh"
module burst_read_address_sequencer_bench;
    logic          clk = 1'b0, reset = 1'b1, cfgWriteEn = 1'b0, cfgWriteSel = 1'b0, cfgReadEn = 1'b0;
    logic          cfgReadSel = 1'b0;
    logic          chipSelectN, addr_valid_strobe_n, resetPinN, wordValid, readyOut, statusOut;
    logic [15:0]   bankBusy = '0, cfgWriteData = '0, cfgReadData;
    logic [23:0]   startAddr, wordAddr, a, qa[$];
    int            error_cnt = 0, check_count = 0, seed = 71291, cyc = 0, takeCyc = 0, n, c, qc[$];
    always #12.5 clk = ~clk;
    brs_sequencer uut (.clk(clk), .reset(reset), .chipSelectN(chipSelectN), .bankBusy(bankBusy),
        .addr_valid_strobe_n(addr_valid_strobe_n), .resetPinN(resetPinN), .startAddr(startAddr),
        .cfgWriteEn(cfgWriteEn), .cfgWriteSel(cfgWriteSel), .cfgWriteData(cfgWriteData), .cfgReadEn(cfgReadEn),
        .cfgReadSel(cfgReadSel), .cfgReadData(cfgReadData), .wordAddr(wordAddr), .wordValid(wordValid),
        .readyOut(readyOut), .statusOut(statusOut));
    brs_host_model #(.ADDR_W(24)) host (.clk(clk), .chipSelectN(chipSelectN),
        .addr_valid_strobe_n(addr_valid_strobe_n), .resetPinN(resetPinN), .startAddr(startAddr));
    // a take clears the log; the word seen at the take edge still belongs to the old burst
    always @(posedge clk) begin
        cyc++;
        if (!chipSelectN && resetPinN && !addr_valid_strobe_n) begin
            qa.delete();
            qc.delete();
            takeCyc = cyc;
        end else if (wordValid && cyc > takeCyc + 1) begin
            qa.push_back(wordAddr);
            qc.push_back(cyc);
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic conclude;
        if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    task automatic wcfg(input logic s, input logic [15:0] d);
        @(negedge clk);
        {cfgWriteEn, cfgWriteSel, cfgWriteData} = {1'b1, s, d};
        @(negedge clk);
        cfgWriteEn = 1'b0;
    endtask : wcfg
    task automatic rcfg(input logic s, input logic [15:0] e);
        @(negedge clk);
        {cfgReadEn, cfgReadSel} = {1'b1, s};
        @(negedge clk);
        cfgReadEn = 1'b0;
        @(negedge clk);
        cmp(cfgReadData, e);
    endtask : rcfg
    task automatic waitw(input int k);
        for (int i = 0; i < 600 && qa.size() < k; i++) @(negedge clk);
        if (qa.size() < k) error_cnt++;
        if (qa.size() < k) conclude();
    endtask : waitw
    function automatic logic [23:0] nxt(input logic [23:0] x, input int sz, input bit wr);
        if (sz > 0 && wr) return (x & ~24'(sz - 1)) | ((x + 24'h00_0001) & 24'(sz - 1));
        return x + 24'h00_0001;
    endfunction : nxt
    // line gap depends on the start offset inside its eight-word slot
    task automatic check(input logic [23:0] s, input int sz, input bit wr, input int lat, input int k);
        logic [23:0] e;
        int          x;
        e = s;
        x = int'(s[2:0]) + lat - 9;
        if (x < 0) x = 0;
        cmp(qc[0] - takeCyc, lat + 1);
        for (int i = 0; i < k; i++) begin
            cmp(qa[i], e);
            if (i > 0) cmp(qc[i] - qc[i-1], (e[6:0] == 0 && !(sz > 0 && wr)) ? x + 1 : 1);
            e = nxt(e, sz, wr);
        end
    endtask : check
    initial begin
        repeat (8) @(negedge clk);
        reset = 1'b0;
        rcfg(0, `BRS_CFG0_RESET);
        rcfg(1, `BRS_CFG1_RESET);
        for (int m = 0; m < 6; m++) begin
            c = {$random(seed)} % 6;
            wcfg(0, 16'((`BRS_CFG0_RESET & 16'hc7f0) | (c << 11) | ((m < 3) << 3) | (2 + m % 3)));
            rcfg(0, 16'((`BRS_CFG0_RESET & 16'hc7f0) | (c << 11) | ((m < 3) << 3) | (2 + m % 3)));
            a = (m == 0) ? 24'h00_003c : (m == 3) ? 24'h00_007c : 24'($random(seed));
            host.start(a);
            waitw(8 << (m % 3));
            repeat (40) @(negedge clk);
            check(a, 8 << (m % 3), m < 3, 8 + c, 8 << (m % 3));
            cmp(qa.size(), 8 << (m % 3));
        end
        wcfg(0, `BRS_CFG0_RESET);
        host.start(24'hff_fffe);
        waitw(4);
        check(24'hff_fffe, 0, 1, 13, 4);
        host.start(24'h12_3470);
        waitw(3);
        check(24'h12_3470, 0, 1, 13, 3);
        for (int v = 0; v < 2; v++) begin
            host.start(24'($random(seed)));
            waitw(2);
            host.stop(v);
            repeat (3) @(negedge clk);
            n = qa.size();
            repeat (30) @(negedge clk);
            cmp(qa.size(), n);
        end
        bankBusy = 16'h0002;
        host.start(24'h0f_fffe);
        for (int i = 0; i < 100 && statusOut !== 1'b1; i++) @(negedge clk);
        cmp(statusOut, 1);
        if (statusOut !== 1'b1) conclude();
        // the crossing word is logged one edge after status rises
        @(negedge clk);
        n = qa.size();
        repeat (20) @(negedge clk);
        cmp(qa.size(), n);
        check(24'h0f_fffe, 0, 1, 13, 2);
        bankBusy = '0;
        host.start(24'h00_0100);
        waitw(1);
        cmp(statusOut, 0);
        check(24'h00_0100, 0, 1, 13, 1);
        // short latency, ready one cycle early and active low
        wcfg(1, 16'h0000);
        wcfg(0, 16'(`BRS_CFG0_RESET & 16'hfaff));
        host.start(24'h00_0200);
        waitw(2);
        cmp(readyOut, 0);
        check(24'h00_0200, 0, 1, 7, 2);
        host.stop(0);
        repeat (3) @(negedge clk);
        cmp(readyOut, 1);
        conclude();
    end
endmodule : burst_read_address_sequencer_bench
